// >>> hw/gate_scan_pkg.sv
// constants for the gate scan configuration decoder
package gate_scan_pkg;
	// command opcodes
	localparam logic [7:0] OP_GATE_SETUP = 8'h01;
	localparam logic [7:0] OP_BOOST_SOFT = 8'h0C;
	localparam logic [7:0] OP_SCAN_START = 8'h0F;
	localparam logic [7:0] OP_SW_RESET = 8'h12;

	// parameter byte indices within a command
	localparam logic [1:0] IDX_FIRST = 2'h0;
	localparam logic [1:0] IDX_SECOND = 2'h1;
	localparam logic [1:0] IDX_THIRD = 2'h2;
	localparam logic [1:0] IDX_DONE = 2'h3;

	// field positions inside parameter bytes
	localparam int POS_HIGH_BIT = 0;
	localparam int POS_FIRST_GATE = 2;
	localparam int POS_INTERLACE = 1;
	localparam int POS_DIRECTION = 0;
	localparam int POS_FIXED_ONE = 7;

	// values after reset
	localparam logic [8:0] RST_LINE_COUNT = 9'h012B;
	localparam logic RST_OPTION = 1'b0;
	localparam logic [7:0] RST_PHASE1 = 8'h87;
	localparam logic [7:0] RST_PHASE2 = 8'h86;
	localparam logic [7:0] RST_PHASE3 = 8'h85;
	localparam logic [8:0] RST_START_POS = 9'h0000;
	localparam logic RST_BOOST_EN = 1'b0;
	// pin synchronisers rest deselected, in command mode
	localparam logic [1:0] RST_PINS = 2'b01;

	// last gate index, used when scanning bottom to top
	localparam logic [8:0] LAST_GATE = 9'h012B;

	// synchroniser width, one bit for each pin input
	localparam int SYNC_STAGES = 2;

	// command decode state, gray coded
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_GATE = 2'b01,
		ST_BOOST = 2'b11,
		ST_START = 2'b10
	} cmd_state_t;
endpackage

// >>> hw/pin_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] pin_in,
	output logic [WIDTH-1:0] pin_sync_out
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stable_ff;

	// first stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					meta_ff[i] <= RST_VAL[i];
					stable_ff[i] <= RST_VAL[i];
				end else begin
					meta_ff[i] <= pin_in[i];
					stable_ff[i] <= meta_ff[i];
				end
			end
		end
	endgenerate

	assign pin_sync_out = stable_ff;
endmodule

// >>> hw/gate_scan_config_decoder.sv
// command decoder and storage for gate scan and booster soft start setup
`timescale 1ns/1ps

// How it works
// - opcode 01 takes three bytes: count low, count bit 8, options
// - option bit 2 set makes G1 first, swapping gate pairs
// - option bit 1 set scans even gates first, then odd gates
// - option bit 0 set scans 299 down to 0; options reset to zero
// - opcode 0C enables booster, takes three phase bytes, bit 7 forced one
// - phase settings reset to 87h, 86h and 85h
// - opcode 0F takes start position low byte then bit 8; host keeps 0..299
// - effective start gate is the position, or 299 minus it when reversed
// - data/command line low marks opcode, high marks parameter
// - bytes accepted only while active-low chip select is low
module gate_scan_config_decoder (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic dc_pin,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	output logic [8:0] gate_line_count,
	output logic first_gate_select,
	output logic interlace_order_select,
	output logic scan_direction_select,
	output logic booster_enable,
	output logic [7:0] soft_start_phase1,
	output logic [7:0] soft_start_phase2,
	output logic [7:0] soft_start_phase3,
	output logic [8:0] scan_start_position,
	output logic [8:0] effective_start_gate,
	output logic cmd_busy
);
	logic [1:0] pins_sync;
	logic cs_n_s;
	logic dc_s;
	logic take_cmd;
	logic take_param;

	gate_scan_pkg::cmd_state_t state_ff;
	gate_scan_pkg::cmd_state_t nxt_state;
	logic [1:0] idx_ff;
	logic [1:0] nxt_idx;

	logic [8:0] count_ff;
	logic [8:0] nxt_count;
	logic first_ff;
	logic nxt_first;
	logic interlace_ff;
	logic nxt_interlace;
	logic dir_ff;
	logic nxt_dir;
	logic boost_ff;
	logic nxt_boost;
	logic [7:0] ph1_ff;
	logic [7:0] nxt_ph1;
	logic [7:0] ph2_ff;
	logic [7:0] nxt_ph2;
	logic [7:0] ph3_ff;
	logic [7:0] nxt_ph3;
	logic [8:0] pos_ff;
	logic [8:0] nxt_pos;
	logic [8:0] eff_ff;
	logic [8:0] nxt_eff;

	// phase bytes always carry a one in the top bit
	function automatic logic [7:0] phase_byte(input logic [7:0] b);
		logic [7:0] r;
		r = b;
		r[gate_scan_pkg::POS_FIXED_ONE] = 1'b1;
		return r;
	endfunction

	// pins come from the host, outside our clock, so resynchronise
	pin_sync #(
		.WIDTH(gate_scan_pkg::SYNC_STAGES),
		.RST_VAL(gate_scan_pkg::RST_PINS)
	) u_pin_sync (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.pin_in({dc_pin, cs_n_pin}),
		.pin_sync_out(pins_sync)
	);

	assign cs_n_s = pins_sync[0];
	assign dc_s = pins_sync[1];

	assign take_cmd = byte_valid && !cs_n_s && !dc_s;
	assign take_param = byte_valid && !cs_n_s && dc_s;

	// command sequencer: opcode picks the state, parameters step the index
	always_comb begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		if (take_cmd) begin
			nxt_idx = gate_scan_pkg::IDX_FIRST;
			unique case (byte_data)
				gate_scan_pkg::OP_GATE_SETUP: nxt_state = gate_scan_pkg::ST_GATE;
				gate_scan_pkg::OP_BOOST_SOFT: nxt_state = gate_scan_pkg::ST_BOOST;
				gate_scan_pkg::OP_SCAN_START: nxt_state = gate_scan_pkg::ST_START;
				default: nxt_state = gate_scan_pkg::ST_IDLE;
			endcase
		end else if (take_param && state_ff != gate_scan_pkg::ST_IDLE) begin
			// surplus parameters are dropped once the command is full
			if (idx_ff != gate_scan_pkg::IDX_DONE) begin
				nxt_idx = idx_ff + 2'h1;
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			state_ff <= gate_scan_pkg::ST_IDLE;
			idx_ff <= gate_scan_pkg::IDX_FIRST;
		end else begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
		end
	end

	// field storage, each parameter byte lands as soon as it arrives
	always_comb begin
		nxt_count = count_ff;
		nxt_first = first_ff;
		nxt_interlace = interlace_ff;
		nxt_dir = dir_ff;
		nxt_boost = boost_ff;
		nxt_ph1 = ph1_ff;
		nxt_ph2 = ph2_ff;
		nxt_ph3 = ph3_ff;
		nxt_pos = pos_ff;
		if (take_cmd && byte_data == gate_scan_pkg::OP_SW_RESET) begin
			// software reset restores every default
			nxt_count = gate_scan_pkg::RST_LINE_COUNT;
			nxt_first = gate_scan_pkg::RST_OPTION;
			nxt_interlace = gate_scan_pkg::RST_OPTION;
			nxt_dir = gate_scan_pkg::RST_OPTION;
			nxt_boost = gate_scan_pkg::RST_BOOST_EN;
			nxt_ph1 = gate_scan_pkg::RST_PHASE1;
			nxt_ph2 = gate_scan_pkg::RST_PHASE2;
			nxt_ph3 = gate_scan_pkg::RST_PHASE3;
			nxt_pos = gate_scan_pkg::RST_START_POS;
		end else if (take_cmd && byte_data == gate_scan_pkg::OP_BOOST_SOFT) begin
			nxt_boost = 1'b1;
		end else if (take_param) begin
			unique case (state_ff)
				gate_scan_pkg::ST_GATE: begin
					if (idx_ff == gate_scan_pkg::IDX_FIRST) begin
						nxt_count[7:0] = byte_data;
					end else if (idx_ff == gate_scan_pkg::IDX_SECOND) begin
						nxt_count[8] = byte_data[gate_scan_pkg::POS_HIGH_BIT];
					end else if (idx_ff == gate_scan_pkg::IDX_THIRD) begin
						nxt_first = byte_data[gate_scan_pkg::POS_FIRST_GATE];
						nxt_interlace = byte_data[gate_scan_pkg::POS_INTERLACE];
						nxt_dir = byte_data[gate_scan_pkg::POS_DIRECTION];
					end
				end
				gate_scan_pkg::ST_BOOST: begin
					if (idx_ff == gate_scan_pkg::IDX_FIRST) begin
						nxt_ph1 = phase_byte(byte_data);
					end else if (idx_ff == gate_scan_pkg::IDX_SECOND) begin
						nxt_ph2 = phase_byte(byte_data);
					end else if (idx_ff == gate_scan_pkg::IDX_THIRD) begin
						nxt_ph3 = phase_byte(byte_data);
					end
				end
				gate_scan_pkg::ST_START: begin
					if (idx_ff == gate_scan_pkg::IDX_FIRST) begin
						nxt_pos[7:0] = byte_data;
					end else if (idx_ff == gate_scan_pkg::IDX_SECOND) begin
						nxt_pos[8] = byte_data[gate_scan_pkg::POS_HIGH_BIT];
					end
				end
				gate_scan_pkg::ST_IDLE: begin
					nxt_pos = pos_ff;
				end
			endcase
		end
	end

	// effective start gate
	// registered from next values so it never lags the stored fields;
	// out-of-range positions wrap when reversed, the host must keep them legal
	always_comb begin
		if (nxt_dir) begin
			nxt_eff = gate_scan_pkg::LAST_GATE - nxt_pos;
		end else begin
			nxt_eff = nxt_pos;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			count_ff <= gate_scan_pkg::RST_LINE_COUNT;
			first_ff <= gate_scan_pkg::RST_OPTION;
			interlace_ff <= gate_scan_pkg::RST_OPTION;
			dir_ff <= gate_scan_pkg::RST_OPTION;
			boost_ff <= gate_scan_pkg::RST_BOOST_EN;
			ph1_ff <= gate_scan_pkg::RST_PHASE1;
			ph2_ff <= gate_scan_pkg::RST_PHASE2;
			ph3_ff <= gate_scan_pkg::RST_PHASE3;
			pos_ff <= gate_scan_pkg::RST_START_POS;
			eff_ff <= gate_scan_pkg::RST_START_POS;
		end else begin
			count_ff <= nxt_count;
			first_ff <= nxt_first;
			interlace_ff <= nxt_interlace;
			dir_ff <= nxt_dir;
			boost_ff <= nxt_boost;
			ph1_ff <= nxt_ph1;
			ph2_ff <= nxt_ph2;
			ph3_ff <= nxt_ph3;
			pos_ff <= nxt_pos;
			eff_ff <= nxt_eff;
		end
	end

	// outputs straight from flip-flops
	assign gate_line_count = count_ff;
	assign first_gate_select = first_ff;
	assign interlace_order_select = interlace_ff;
	assign scan_direction_select = dir_ff;
	assign booster_enable = boost_ff;
	assign soft_start_phase1 = ph1_ff;
	assign soft_start_phase2 = ph2_ff;
	assign soft_start_phase3 = ph3_ff;
	assign scan_start_position = pos_ff;
	assign effective_start_gate = eff_ff;
	// command open and still expecting parameters
	assign cmd_busy = (state_ff == gate_scan_pkg::ST_GATE &&
		idx_ff != gate_scan_pkg::IDX_DONE) ||
		(state_ff == gate_scan_pkg::ST_BOOST &&
		idx_ff != gate_scan_pkg::IDX_DONE) ||
		(state_ff == gate_scan_pkg::ST_START &&
		idx_ff < gate_scan_pkg::IDX_THIRD);
endmodule

// >>> verif/gate_host_model.sv
// host model driving command and parameter bytes at the pins
`timescale 1ns/1ps
module gate_host_model (
	input wire logic ref_clk,
	output logic cs_n_pin,
	output logic dc_pin,
	output logic byte_valid,
	output logic [7:0] byte_data
);
	// idle: deselected, no byte offered
	initial begin
		cs_n_pin = 1'b1;
		dc_pin = 1'b0;
		byte_valid = 1'b0;
		byte_data = 8'h00;
	end

	task automatic send(input logic sel_n, input logic dc,
		input logic [7:0] d);
		@(negedge ref_clk);
		cs_n_pin = sel_n;
		dc_pin = dc;
		repeat (2) @(negedge ref_clk);
		byte_valid = 1'b1;
		byte_data = d;
		@(negedge ref_clk);
		byte_valid = 1'b0;
		// stale byte inverted so it never passes for fresh data
		byte_data = ~d;
	endtask
endmodule

// >>> verif/gate_scan_monitor.sv
// assertion checker for the gate scan configuration decoder
`timescale 1ns/1ps
module gate_scan_monitor (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n_pin,
	input wire logic dc_pin,
	input wire logic byte_valid,
	input wire logic [7:0] byte_data,
	input wire logic [8:0] gate_line_count,
	input wire logic first_gate_select,
	input wire logic interlace_order_select,
	input wire logic scan_direction_select,
	input wire logic booster_enable,
	input wire logic [7:0] soft_start_phase1,
	input wire logic [7:0] soft_start_phase2,
	input wire logic [7:0] soft_start_phase3,
	input wire logic [8:0] scan_start_position,
	input wire logic [8:0] effective_start_gate,
	input wire logic cmd_busy
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	// pins seen two edges late, as the synchronisers do
	sequence s_op(logic [7:0] op);
		byte_valid && !$past(cs_n_pin, 2) && !$past(dc_pin, 2)
			&& byte_data == op;
	endsequence
	sequence s_par;
		byte_valid && !$past(cs_n_pin, 2) && $past(dc_pin, 2);
	endsequence

	a_count_low: assert property (s_op(8'h01) ##4 s_par |=>
		gate_line_count[7:0] == $past(byte_data)) else $error("count low");
	a_option_bits: assert property (s_op(8'h01) ##4 s_par ##4 s_par
		##4 s_par |=> {first_gate_select, interlace_order_select,
		scan_direction_select} == $past(byte_data[2:0]))
		else $error("option bits");
	a_boost_on: assert property (s_op(8'h0C) |=> booster_enable)
		else $error("booster enable");
	a_phase_one: assert property (s_op(8'h0C) ##4 s_par |=>
		soft_start_phase1 == ($past(byte_data) | 8'h80))
		else $error("phase one");
	a_fixed_one: assert property (soft_start_phase1[7]
		&& soft_start_phase2[7] && soft_start_phase3[7]) else $error("bit 7");
	a_start_high: assert property (s_op(8'h0F) ##4 s_par ##4 s_par |=>
		scan_start_position[8] == $past(byte_data[0])) else $error("pos high");
	a_eff_gate: assert property (effective_start_gate ==
		(scan_direction_select ? 9'h012B - scan_start_position
		: scan_start_position)) else $error("effective gate");
	a_cs_ignored: assert property (byte_valid && $past(cs_n_pin, 2) |=>
		$stable({gate_line_count, soft_start_phase1, scan_start_position}))
		else $error("deselected byte taken");
	a_busy_pos: assert property (s_op(8'h0F) |=> cmd_busy)
		else $error("busy");
endmodule

bind gate_scan_config_decoder gate_scan_monitor mon (.*);

// >>> verif/gate_scan_config_decoder_tb.sv
// self-checking bench for the gate scan configuration decoder
`timescale 1ns/1ps
module gate_scan_config_decoder_tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic cs_n_pin, dc_pin, byte_valid, cmd_busy, booster_enable;
	logic first_gate_select, interlace_order_select, scan_direction_select;
	logic [7:0] byte_data, soft_start_phase1, soft_start_phase2;
	logic [7:0] soft_start_phase3, ph1, ph2, ph3;
	logic [8:0] gate_line_count, scan_start_position, effective_start_gate;
	logic [8:0] cnt, pos;
	logic [2:0] opt;
	int n_errors = 0;
	int total_checks = 0;
	int cycles = 0;

	gate_scan_config_decoder dut (.*);
	gate_host_model host (.*);

	always #25 ref_clk = ~ref_clk;

	// hang guard, well past the expected run length
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			complete_run();
		end
	end

	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	function automatic logic [8:0] exp_eff(input logic [8:0] p, input logic d);
		return d ? 9'h012B - p : p;
	endfunction

	// every stored field at its reset value, no command open
	task automatic check_defaults();
		check(gate_line_count, 9'h012B);
		check({1'b0, soft_start_phase1}, 9'h087);
		check({1'b0, soft_start_phase2}, 9'h086);
		check({1'b0, soft_start_phase3}, 9'h085);
		check(scan_start_position, 9'h000);
		check(effective_start_gate, 9'h000);
		check({6'h00, first_gate_select, interlace_order_select,
			scan_direction_select}, 9'h000);
		check({7'h00, booster_enable, cmd_busy}, 9'h000);
	endtask

	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// defaults, then random setups with corner cases first
	initial begin
		void'($urandom(57054));
		repeat (6) @(negedge ref_clk);
		rst_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		check_defaults();
		for (int i = 0; i < 24; i++) begin
			cnt = 9'($urandom);
			opt = 3'($urandom);
			pos = 9'($urandom % 300);
			ph1 = 8'($urandom) | 8'h80;
			ph2 = 8'($urandom) | 8'h80;
			ph3 = 8'($urandom) | 8'h80;
			if (i < 2) begin
				opt = 3'h7;
				pos = i ? 9'h000 : 9'h012B;
			end
			host.send(1'b0, 1'b0, gate_scan_pkg::OP_GATE_SETUP);
			host.send(1'b0, 1'b1, cnt[7:0]);
			host.send(1'b0, 1'b1, {7'h00, cnt[8]});
			// deselected byte would steal the option slot if taken
			if (i[0]) host.send(1'b1, 1'b1, {5'h00, ~opt});
			host.send(1'b0, 1'b1, {5'h00, opt});
			host.send(1'b0, 1'b0, gate_scan_pkg::OP_BOOST_SOFT);
			host.send(1'b0, 1'b1, ph1);
			host.send(1'b0, 1'b1, ph2);
			host.send(1'b0, 1'b1, ph3);
			host.send(1'b0, 1'b0, gate_scan_pkg::OP_SCAN_START);
			host.send(1'b0, 1'b1, pos[7:0]);
			// half-written position still waits for its high byte
			check({8'h00, cmd_busy}, 9'h001);
			host.send(1'b0, 1'b1, {7'h00, pos[8]});
			// a surplus byte past the position must be dropped
			if (i[1]) host.send(1'b0, 1'b1, ~pos[7:0]);
			@(negedge ref_clk);
			check(gate_line_count, cnt);
			check({6'h00, first_gate_select, interlace_order_select,
				scan_direction_select}, {6'h00, opt});
			check({1'b0, soft_start_phase1}, {1'b0, ph1});
			check({8'h00, booster_enable}, 9'h001);
			check(scan_start_position, pos);
			check(effective_start_gate, exp_eff(pos, opt[0]));
			check({1'b0, soft_start_phase2}, {1'b0, ph2});
			check({1'b0, soft_start_phase3}, {1'b0, ph3});
			check({8'h00, cmd_busy}, 9'h000);
		end
		// software reset, then an unknown opcode whose byte is dropped
		host.send(1'b0, 1'b0, gate_scan_pkg::OP_SW_RESET);
		host.send(1'b0, 1'b0, 8'h20);
		host.send(1'b0, 1'b1, 8'h55);
		@(negedge ref_clk);
		check_defaults();
		complete_run();
	end
endmodule
